// File: hw/irq_flag_prio_defs.vh
`ifndef IRQ_FLAG_PRIO_DEFS_VH
`define IRQ_FLAG_PRIO_DEFS_VH
// Register byte offsets
`define OFS_FLAGS        8'h00
`define OFS_PRIO_CC      8'h04
`define OFS_PRIO_U3      8'h08
`define OFS_PRIO_S3U4    8'h0C
`define OFS_IRQ_STATUS   8'h10
`define OFS_IRQ_MASK     8'h14
`define OFS_PWR_CTRL     8'h18
`define OFS_ENABLE       8'h1C
`define OFS_CAL          8'h20
`define OFS_NVM          8'h24
// Writable bit masks
`define FLAGS_MASK       16'h3FE3
`define PRIO_CC_MASK     16'h7777
`define PRIO_U3_MASK     16'h7770
`define PRIO_S3U4_MASK   16'h7777
// Reset values
`define PRIO_CC_RST      16'h4444
`define PRIO_U3_RST      16'h4440
`define PRIO_S3U4_RST    16'h4444
`define FLAGS_RST        16'h0000
// Status bit positions
`define ST_FLAG_SET      0
`define ST_WAKE          1
`define ST_WDT_TO        2
// Power control bits
`define PWR_ENTER_BIT    0
`define PWR_WDT_EN_BIT   1
`define PWR_FAIL_SAFE_CLOCK_MONITOR_EN_BIT  2
`endif

// File: hw/irq_flag_priority_idle_wake.v
// Functional notes
// - Flag bit reads 1 after its source requested, else 0.
// - Unimplemented bits ignore writes and read zero.
// - Ordinary registers reset identically for every reset type.
// - Calibration and nonvolatile control reset only on power-on.
// - Flag layout: port 13, compare 12-9, capture 8-5, serial2 1-0.
// - Priority: ser3 event 14-12, fault 10-8, uart4 tx 6-4, rx 2-0.
// - Idle stops CPU execution while system clock keeps running.
// - Idle entry clears the watchdog counter.
// - Peripherals keep running in idle; peripheralRun is always high.
// - Low-power oscillator runs in idle if watchdog or monitor enabled.
// - Wake on enabled interrupt, any reset, or watchdog time-out.
// - Wake restores CPU clock at once and resumes execution.
// - Interrupt during power-save instruction waits until entry completes.
`timescale 1ns/1ps
`include "irq_flag_prio_defs.vh"
module irq_flag_priority_idle_wake #(
   parameter NUM_FLAGS = 16
) (
   input  wire                 clock,
   input  wire                 reset,
   input  wire                 porReset,
   input  wire                 hsel,
   input  wire [31:0]          haddr,
   input  wire [1:0]           htrans,
   input  wire                 hwrite,
   input  wire [2:0]           hsize,
   input  wire [31:0]          hwdata,
   input  wire                 hready,
   output reg  [31:0]          hrdata,
   output reg                  hreadyout,
   output reg                  hresp,
   input  wire [NUM_FLAGS-1:0] sourceEvent,
   input  wire                 powerSaveExec,
   input  wire                 wdtTimeout,
   output reg                  cpuRun,
   output reg                  systemClockOn,
   output reg                  peripheralRun,
   output reg                  lowPowerOscOn,
   output reg                  wdtClear,
   output reg                  idleMode,
   output reg                  irqRequest,
   output reg                  irqOut
);
   localparam ST_RUN   = 2'd0;
   localparam ST_ENTER = 2'd1;
   localparam ST_IDLE  = 2'd2;

   reg  [15:0] flags_q;
   reg  [15:0] prioCc_q;
   reg  [15:0] prioU3_q;
   reg  [15:0] prioS3u4_q;
   reg  [15:0] enable_q;
   reg  [2:0]  status_q;
   reg  [2:0]  mask_q;
   reg  [2:0]  pwrCtrl_q;
   reg  [15:0] cal_q;
   reg  [15:0] nvm_q;
   reg  [1:0]  state_q;
   reg         heldIrq_q;
   reg         phWrite_q;
   reg  [7:0]  phAddr_q;

   reg  [15:0] flags_d;
   reg  [2:0]  level [0:15];
   reg  [15:0] active;
   reg  [2:0]  evt;
   reg  [31:0] rdData;
   reg         mapped;
   integer     i;

   wire        addrPhase  = hsel && hready && htrans[1];
   wire        wrCal      = phWrite_q && (phAddr_q == `OFS_CAL);
   wire        wrNvm      = phWrite_q && (phAddr_q == `OFS_NVM);
   wire        rdStatus   = addrPhase && !hwrite && (haddr[7:0] == `OFS_IRQ_STATUS);
   wire        enterReq   = phWrite_q && (phAddr_q == `OFS_PWR_CTRL) &&
                            hwdata[`PWR_ENTER_BIT];
   wire        anyPending = |active;

   // Per-source priority levels; unmatched sources get level zero
   always @* begin
      for (i = 0; i < 16; i = i + 1)
         level[i] = 3'h0;
      level[11] = prioCc_q[14:12];
      level[10] = prioCc_q[10:8];
      level[9]  = prioCc_q[6:4];
      level[8]  = prioCc_q[2:0];
      level[13] = prioU3_q[14:12];
      level[12] = prioU3_q[10:8];
      level[5]  = prioS3u4_q[14:12];
      level[6]  = prioS3u4_q[10:8];
      level[7]  = prioS3u4_q[6:4];
      level[1]  = prioS3u4_q[2:0];
      level[0]  = prioU3_q[6:4];
      for (i = 0; i < 16; i = i + 1)
         active[i] = flags_q[i] && enable_q[i] && (level[i] != 3'h0);
   end

   always @* begin
      flags_d = flags_q;
      if (phWrite_q && phAddr_q == `OFS_FLAGS)
         flags_d = hwdata[15:0];
      flags_d = (flags_d | sourceEvent[15:0]) & `FLAGS_MASK;
   end

   always @* begin
      rdData = 32'h0000_0000;
      mapped = 1'b1;
      case (haddr[7:0])
         `OFS_FLAGS:      rdData[15:0] = flags_q;
         `OFS_PRIO_CC:    rdData[15:0] = prioCc_q;
         `OFS_PRIO_U3:    rdData[15:0] = prioU3_q;
         `OFS_PRIO_S3U4:  rdData[15:0] = prioS3u4_q;
         `OFS_IRQ_STATUS: rdData[2:0]  = status_q;
         `OFS_IRQ_MASK:   rdData[2:0]  = mask_q;
         `OFS_PWR_CTRL:   rdData[2:0]  = {pwrCtrl_q[2:1], idleMode};
         `OFS_ENABLE:     rdData[15:0] = enable_q;
         `OFS_CAL:        rdData[15:0] = cal_q;
         `OFS_NVM:        rdData[15:0] = nvm_q;
         default:         mapped = 1'b0;
      endcase
   end

   always @* begin
      evt = 3'b000;
      evt[`ST_FLAG_SET] = |(flags_d & ~flags_q);
      evt[`ST_WAKE]     = (state_q == ST_IDLE) && (anyPending || wdtTimeout);
      evt[`ST_WDT_TO]   = wdtTimeout;
   end

   // Power-on only domain
   always @(posedge clock or posedge porReset) begin
      if (porReset) begin
         cal_q <= 16'h0000;
         nvm_q <= 16'h0000;
      end else begin
         if (wrCal)
            cal_q <= hwdata[15:0];
         if (wrNvm)
            nvm_q <= hwdata[15:0];
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         flags_q    <= `FLAGS_RST;
         prioCc_q   <= `PRIO_CC_RST;
         prioU3_q   <= `PRIO_U3_RST;
         prioS3u4_q <= `PRIO_S3U4_RST;
         enable_q   <= 16'h0000;
         status_q   <= 3'b000;
         mask_q     <= 3'b000;
         pwrCtrl_q  <= 3'b000;
         phWrite_q  <= 1'b0;
         phAddr_q   <= 8'h00;
         hrdata     <= 32'h0000_0000;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         state_q    <= ST_RUN;
         heldIrq_q  <= 1'b0;
         cpuRun     <= 1'b1;
         systemClockOn <= 1'b1;
         peripheralRun <= 1'b1;
         lowPowerOscOn <= 1'b0;
         wdtClear   <= 1'b0;
         idleMode   <= 1'b0;
         irqRequest <= 1'b0;
         irqOut     <= 1'b0;
      end else begin
         phWrite_q <= addrPhase && hwrite;
         phAddr_q  <= {haddr[7:2], 2'b00};
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (addrPhase && !hwrite)
            hrdata <= mapped ? rdData : 32'h0000_0000;
         flags_q <= flags_d;
         if (phWrite_q) begin
            case (phAddr_q)
               `OFS_PRIO_CC:   prioCc_q   <= hwdata[15:0] & `PRIO_CC_MASK;
               `OFS_PRIO_U3:   prioU3_q   <= hwdata[15:0] & `PRIO_U3_MASK;
               `OFS_PRIO_S3U4: prioS3u4_q <= hwdata[15:0] & `PRIO_S3U4_MASK;
               `OFS_IRQ_MASK:  mask_q     <= hwdata[2:0];
               `OFS_PWR_CTRL:  pwrCtrl_q  <= {hwdata[2:1], 1'b0};
               `OFS_ENABLE:    enable_q   <= hwdata[15:0];
               default:        ;
            endcase
         end
         // Read clears, new events win
         status_q <= (rdStatus ? 3'b000 : status_q) | evt;
         irqOut   <= |(((rdStatus ? 3'b000 : status_q) | evt) & mask_q);

         wdtClear <= 1'b0;
         case (state_q)
            ST_RUN: begin
               if (enterReq || powerSaveExec)
                  state_q <= ST_ENTER;
            end
            ST_ENTER: begin
               // Entry completes before any held request can wake
               heldIrq_q <= anyPending;
               state_q   <= ST_IDLE;
               cpuRun    <= 1'b0;
               idleMode  <= 1'b1;
               wdtClear  <= 1'b1;
            end
            ST_IDLE: begin
               if (anyPending || heldIrq_q || wdtTimeout) begin
                  state_q   <= ST_RUN;
                  cpuRun    <= 1'b1;
                  idleMode  <= 1'b0;
                  heldIrq_q <= 1'b0;
               end
            end
            default: state_q <= ST_RUN;
         endcase
         systemClockOn <= 1'b1;
         peripheralRun <= 1'b1;
         lowPowerOscOn <= pwrCtrl_q[`PWR_WDT_EN_BIT] ||
                          pwrCtrl_q[`PWR_FAIL_SAFE_CLOCK_MONITOR_EN_BIT];
         irqRequest <= anyPending && (state_q != ST_ENTER);
      end
   end
endmodule

// File: verif/irq_flag_priority_idle_wake_checker.sv
`timescale 1ns/1ps
module irq_flag_priority_idle_wake_checker (
   input wire logic clock,
   input wire logic reset,
   input wire logic powerSaveExec,
   input wire logic wdtTimeout,
   input wire logic cpuRun,
   input wire logic systemClockOn,
   input wire logic peripheralRun,
   input wire logic wdtClear,
   input wire logic idleMode,
   input wire logic irqRequest
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   sequence wakeSeq;
      ##1 (!idleMode && cpuRun);
   endsequence
   sequence enterSeq;
      ##[1:3] idleMode;
   endsequence
   AST_CLOCKS_ON: assert property (systemClockOn && peripheralRun)
      else $error("clock or peripherals stopped");
   AST_IDLE_STOPS_CPU: assert property (idleMode |-> !cpuRun)
      else $error("cpu runs in idle");
   AST_WDT_CLEAR: assert property ($rose(idleMode) |-> wdtClear)
      else $error("no watchdog clear on idle entry");
   AST_WDT_PULSE: assert property (wdtClear |=> !wdtClear)
      else $error("watchdog clear longer than one cycle");
   AST_ENTRY: assert property (powerSaveExec && cpuRun |-> enterSeq)
      else $error("idle not entered");
   AST_WAKE_WDT: assert property (idleMode && wdtTimeout |-> wakeSeq)
      else $error("no wake on watchdog time-out");
   AST_WAKE_IRQ: assert property (idleMode ##1 irqRequest |-> (!idleMode && cpuRun))
      else $error("no wake on enabled interrupt");
   AST_RESET_WAKE: assert property ($fell(reset) |-> cpuRun && !idleMode)
      else $error("not running after reset");
endmodule
bind irq_flag_priority_idle_wake irq_flag_priority_idle_wake_checker chk (
   .clock(clock), .reset(reset), .powerSaveExec(powerSaveExec), .wdtTimeout(wdtTimeout),
   .cpuRun(cpuRun), .systemClockOn(systemClockOn), .peripheralRun(peripheralRun),
   .wdtClear(wdtClear), .idleMode(idleMode), .irqRequest(irqRequest));

// File: verif/event_source_model.sv
`timescale 1ns/1ps
module event_source_model (
   input  wire logic        clock,
   input  wire logic        fire,
   input  wire logic [15:0] pattern,
   output logic      [15:0] sourceEvent
);
   initial sourceEvent = 16'h0000;
   // One-cycle event pulses from the peripherals
   always @(posedge clock) begin
      sourceEvent <= fire ? pattern : 16'h0000;
   end
endmodule

// File: verif/irq_flag_priority_idle_wake_tb_top.sv
`timescale 1ns/1ps
module irq_flag_priority_idle_wake_tb_top;
   logic        clock = 0, reset = 1, porReset = 1, hsel = 0, hwrite = 0, hready = 1;
   logic        evGo = 0, powerSaveExec = 0, wdtTimeout = 0, rdPending = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic [15:0] evPattern = 0, sourceEvent;
   logic        hreadyout, hresp, cpuRun, systemClockOn, peripheralRun;
   logic        lowPowerOscOn, wdtClear, idleMode, irqRequest, irqOut;
   logic [31:0] expQ[$];
   logic [31:0] m[4] = '{32'h3FE3, 32'h7777, 32'h7770, 32'h7777};
   int          error_cnt = 0, checks_done = 0, cycles = 0, seed = 81707;
   always #12.5 clock = ~clock;
   irq_flag_priority_idle_wake uut (.clock(clock), .reset(reset), .porReset(porReset),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .sourceEvent(sourceEvent), .powerSaveExec(powerSaveExec),
      .wdtTimeout(wdtTimeout), .cpuRun(cpuRun), .systemClockOn(systemClockOn),
      .peripheralRun(peripheralRun), .lowPowerOscOn(lowPowerOscOn), .wdtClear(wdtClear),
      .idleMode(idleMode), .irqRequest(irqRequest), .irqOut(irqOut));
   event_source_model src (.clock(clock), .fire(evGo), .pattern(evPattern),
      .sourceEvent(sourceEvent));
   task print_verdict;
      $display("errors=%0d checks=%0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h000000, a};
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      if (!w) expQ.push_back(e);
      rdPending <= !w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rdPending <= 0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1, a, d, 32'h0);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      xfer(0, a, 32'h0, e);
   endtask
   task fire(input logic [15:0] p);
      evPattern <= p;
      evGo <= 1;
      @(posedge clock);
      evGo <= 0;
      repeat (3) @(posedge clock);
      #1;
   endtask
   always @(posedge clock) begin
      if (rdPending && hreadyout === 1'b1) begin
         chk(hrdata, expQ.pop_front());
         chk(hresp, 0);
      end
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      repeat (20) @(posedge clock);
      reset <= 0;
      porReset <= 0;
      @(posedge clock);
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h4444);
      rd(8'h08, 32'h4440);
      rd(8'h0C, 32'h4444);
      wr(8'h14, 32'h1);
      fire(16'h2000);
      chk(irqOut, 1);
      rd(8'h00, 32'h2000);
      rd(8'h10, 32'h1);
      repeat (2) @(posedge clock);
      #1 chk(irqOut, 0);
      wr(8'h14, 32'h0);
      fire(16'h0002);
      chk(irqOut, 0);
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         wr(4 * i, r);
         rd(4 * i, r & m[i]);
      end
      for (int i = 0; i < 4; i++) begin
         wr(4 * i, 32'hFFFFFFFF);
         rd(4 * i, m[i]);
      end
      wr(8'h00, 32'h0);
      rd(8'h00, 32'h0);
      rd(8'h40, 32'h0);
      wr(8'h18, 32'h6);
      repeat (2) @(posedge clock);
      #1 chk(lowPowerOscOn, 1);
      wr(8'h18, 32'h7);
      repeat (4) @(posedge clock);
      #1 chk({cpuRun, idleMode, systemClockOn}, 3'h3);
      @(posedge clock);
      wdtTimeout <= 1;
      @(posedge clock);
      wdtTimeout <= 0;
      repeat (2) @(posedge clock);
      #1 chk(cpuRun, 1);
      wr(8'h1C, 32'h2000);
      powerSaveExec <= 1;
      evPattern <= 16'h2000;
      evGo <= 1;
      @(posedge clock);
      powerSaveExec <= 0;
      evGo <= 0;
      repeat (8) @(posedge clock);
      #1 chk({cpuRun, idleMode}, 2'h2);
      wr(8'h20, 32'h1);
      wr(8'h04, 32'h0);
      reset <= 1;
      @(posedge clock);
      reset <= 0;
      @(posedge clock);
      rd(8'h20, 32'h1);
      rd(8'h04, 32'h4444);
      reset <= 1;
      porReset <= 1;
      @(posedge clock);
      reset <= 0;
      porReset <= 0;
      @(posedge clock);
      rd(8'h20, 32'h0);
      print_verdict();
   end
endmodule
